// >>> pdt_pkg.sv
// Purpose: shared constants and types for the pd transmit timing block
// Assumes: apb with 32-bit data, register index times four is the address
// Notes:   printed register offsets are indexes, not byte addresses
package pdt_pkg;

  localparam int unsigned ADDR_W        = 16;
  // register indexes; byte address is index * 4
  localparam logic [13:0] IDX_PREAMBLE  = 14'h1a06;
  localparam logic [13:0] IDX_BITPERIOD = 14'h1a07;
  localparam logic [13:0] IDX_TURNAROUND = 14'h1a08;
  localparam logic [13:0] IDX_ABORTCAUSE = 14'h1a09;
  localparam logic [13:0] IDX_CONTROL   = 14'h1a40;

  localparam logic [6:0] PREAMBLE_RST   = 7'h40;
  localparam logic [7:0] BITPERIOD_RST  = 8'h00;
  localparam logic [5:0] TURNAROUND_RST = 6'h15;
  localparam logic [7:0] CAUSE_RST      = 8'h00;
  localparam logic [7:0] CAUSE_MASK     = 8'hf7;

  // abort cause bit positions
  localparam int unsigned CB_PROTO_ERR  = 7;
  localparam int unsigned CB_SW_RX      = 6;
  localparam int unsigned CB_AUTO_RX    = 5;
  localparam int unsigned CB_AUTO_BUSY  = 4;
  localparam int unsigned CB_SW_BUSY    = 2;
  localparam int unsigned CB_SW_ABORT   = 1;
  localparam int unsigned CB_GO_OFF     = 0;

  // control register bit positions
  localparam int unsigned CTL_GO        = 0;
  localparam int unsigned CTL_ABORT     = 1;
  localparam int unsigned CTL_ENABLE    = 2;
  localparam int unsigned CTL_BUSY      = 3;
  localparam int unsigned CTL_AUTO      = 4;

  // free-running microsecond tick
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned TICK_TIME_US  = 1;
  localparam int unsigned TICK_CYCLES   =
    (TICK_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [7:0] TICK_LAST      = 8'(TICK_CYCLES - 1);

  localparam int unsigned FIFO_DEPTH    = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TURN = 3'b001,
    ST_PRE  = 3'b010,
    ST_DATA = 3'b011,
    ST_ACK  = 3'b100
  } pdt_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } pdt_word_t;

endpackage : pdt_pkg

// >>> pdt_tx_timing.sv
// Purpose: transmit timing, preamble, turnaround and abort cause logging
// Assumes: all inputs synchronous to CLOCK_I, packet bytes pre-encoded
// Notes:   apb slave answers in the second access cycle
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Contract
// - send exactly preamble_bit_count preamble bits; zero is not rejected
// - each bit lasts bit_period_count_field plus one clock cycles
// - wait turnaround_microseconds ticks before transmitting; zero unchecked
// - once any cause bit is set hardware leaves the register untouched
// - cause bits set by hardware, cleared by software writing one
// - bit 7: protocol error while awaiting goodcrc acknowledgement
// - bit 6: software transmit lost to reception during turnaround
// - bit 5: auto retry lost to reception during turnaround
// - bit 4: auto retry finds line busy after turnaround
// - bit 2: software transmit finds line busy after turnaround
// - bit 1: software abort during software transmit
// - bit 0: go command issued while transmitter disabled
// - every abort pulses the aborted output; all but a software abort of an auto retry log the reason
module pdt_tx_timing
  import pdt_pkg::*;
(
  input  wire logic              CLOCK_I,
  input  wire logic              RESETN_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  input  wire pdt_word_t         S_WORD_I,
  input  wire logic              S_VALID_I,
  output logic                   S_READY_O,
  input  wire logic              RETRY_REQ_I,
  input  wire logic              LINE_BUSY_I,
  input  wire logic              RX_START_I,
  input  wire logic              RX_HRST_I,
  input  wire logic              RX_MSG_I,
  input  wire logic              RX_GOODCRC_I,
  input  wire logic              RX_PING_I,
  input  wire logic              ACK_TIMEOUT_I,
  output logic                   TX_BIT_O,
  output logic                   TX_ACTIVE_O,
  output logic                   TX_ABORTED_O
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  pdt_state_t  state_r;
  pdt_state_t  state_nxt;
  logic [6:0]  preamble_r;
  logic [7:0]  bit_period_r;
  logic [5:0]  turnaround_r;
  logic [7:0]  cause_r;
  logic [7:0]  cause_nxt;
  logic [7:0]  cause_set;
  logic [7:0]  cause_clr;
  logic        tx_en_r;
  logic        auto_r;
  logic        auto_nxt;
  logic        abort_ev;
  logic [7:0]  tick_cnt_r;
  logic        tick;
  logic [5:0]  ta_cnt_r;
  logic [7:0]  bit_cnt_r;
  logic        bit_end;
  logic [6:0]  pre_cnt_r;
  logic [7:0]  shift_r;
  logic [2:0]  bit_idx_r;
  logic        last_r;
  logic        have_byte_r;
  logic        pop;
  logic        pre_done;
  logic        byte_done;
  logic        push;
  pdt_word_t   fifo_mem [FIFO_DEPTH];
  logic        wr_ptr_r;
  logic        rd_ptr_r;
  logic [1:0]  count_r;
  logic [1:0]  count_nxt;
  logic        fifo_valid;
  logic        s_ready_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        setup_hit;
  logic        commit;
  logic        wr_commit;
  logic [13:0] idx;
  logic        idx_ok;
  logic        addr_ok;
  logic [31:0] rd_val;
  logic        go_wr;
  logic        abort_wr;
  logic        rx_begin;
  logic        tx_bit_r;
  logic        tx_active_r;
  logic        tx_aborted_r;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer from flops
  assign idx       = PADDR_I[15:2];
  assign setup_hit = PSEL_I & PENABLE_I & ~pready_r;
  assign commit    = PSEL_I & PENABLE_I & pready_r;
  assign wr_commit = commit & PWRITE_I & ~pslverr_r;

  always_comb begin
    rd_val = 32'h0000_0000;
    idx_ok = 1'b1;
    if (idx == IDX_PREAMBLE) begin
      rd_val[6:0] = preamble_r;
    end else if (idx == IDX_BITPERIOD) begin
      rd_val[7:0] = bit_period_r;
    end else if (idx == IDX_TURNAROUND) begin
      rd_val[5:0] = turnaround_r;
    end else if (idx == IDX_ABORTCAUSE) begin
      rd_val[7:0] = cause_r;
    end else if (idx == IDX_CONTROL) begin
      rd_val[CTL_ENABLE] = tx_en_r;
      rd_val[CTL_BUSY]   = (state_r != ST_IDLE);
      rd_val[CTL_AUTO]   = auto_r;
    end else begin
      idx_ok = 1'b0;
    end
  end

  // misaligned addresses are refused like unmapped ones
  assign addr_ok = idx_ok & (PADDR_I[1:0] == 2'b00);

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_hit;
      pslverr_r <= setup_hit & ~addr_ok;
      if (setup_hit) begin
        prdata_r <= PWRITE_I ? 32'h0000_0000 : rd_val;
      end
    end
  end

  assign go_wr    = wr_commit & (idx == IDX_CONTROL) & PWDATA_I[CTL_GO];
  assign abort_wr = wr_commit & (idx == IDX_CONTROL) & PWDATA_I[CTL_ABORT];

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      preamble_r   <= PREAMBLE_RST;
      bit_period_r <= BITPERIOD_RST;
      turnaround_r <= TURNAROUND_RST;
      tx_en_r      <= 1'b0;
    end else if (wr_commit) begin
      if (idx == IDX_PREAMBLE) begin
        preamble_r <= PWDATA_I[6:0];
      end else if (idx == IDX_BITPERIOD) begin
        bit_period_r <= PWDATA_I[7:0];
      end else if (idx == IDX_TURNAROUND) begin
        turnaround_r <= PWDATA_I[5:0];
      end else if (idx == IDX_CONTROL) begin
        tx_en_r <= PWDATA_I[CTL_ENABLE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer; ready registered so it comes from a flop
  assign fifo_valid = (count_r != 2'd0);
  assign push       = S_VALID_I & s_ready_r;
  // next byte loads on the closing edge of the bit before it: no gap
  assign pre_done   = (state_r == ST_PRE) & bit_end &
                      ((pre_cnt_r + 7'h01) == preamble_r);
  assign byte_done  = (state_r == ST_DATA) & have_byte_r & bit_end &
                      (bit_idx_r == 3'd7);
  assign pop        = fifo_valid & (pre_done | (byte_done & ~last_r) |
                      ((state_r == ST_DATA) & ~have_byte_r));

  always_comb begin
    count_nxt = count_r;
    if (abort_ev) begin
      count_nxt = 2'd0;
    end else if (push & ~pop) begin
      count_nxt = count_r + 2'd1;
    end else if (pop & ~push) begin
      count_nxt = count_r - 2'd1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      count_r   <= 2'd0;
      wr_ptr_r  <= 1'b0;
      rd_ptr_r  <= 1'b0;
      s_ready_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      s_ready_r <= (count_nxt != 2'(FIFO_DEPTH));
      // a flush drops every queued byte, even when no frame was under way
      if (abort_ev) begin
        wr_ptr_r <= 1'b0;
        rd_ptr_r <= 1'b0;
      end else begin
        if (push) begin
          wr_ptr_r <= ~wr_ptr_r;
        end
        if (pop) begin
          rd_ptr_r <= ~rd_ptr_r;
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (push) begin
      fifo_mem[wr_ptr_r] <= S_WORD_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers
  assign tick = (tick_cnt_r == TICK_LAST);

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      tick_cnt_r <= 8'h00;
    end else begin
      tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
    end
  end

  // first tick may come early, hence software adds one
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I || state_r != ST_TURN) begin
      ta_cnt_r <= 6'h00;
    end else if (tick) begin
      ta_cnt_r <= ta_cnt_r + 6'h01;
    end
  end

  assign bit_end = (bit_cnt_r == bit_period_r);

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I || bit_end || pop) begin
      bit_cnt_r <= 8'h00;
    end else if (state_r == ST_PRE ||
                 (state_r == ST_DATA && have_byte_r)) begin
      bit_cnt_r <= bit_cnt_r + 8'h01;
    end else begin
      bit_cnt_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing and abort causes
  assign rx_begin = RX_START_I | RX_HRST_I;

  always_comb begin
    state_nxt = state_r;
    auto_nxt  = auto_r;
    cause_set = 8'h00;
    abort_ev  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (go_wr && !tx_en_r) begin
          cause_set[CB_GO_OFF] = 1'b1;
          abort_ev             = 1'b1;
        end else if (go_wr) begin
          state_nxt = ST_TURN;
          auto_nxt  = 1'b0;
        end else if (RETRY_REQ_I && tx_en_r) begin
          state_nxt = ST_TURN;
          auto_nxt  = 1'b1;
        end
      end
      ST_TURN: begin
        if (rx_begin) begin
          cause_set[CB_SW_RX]   = ~auto_r;
          cause_set[CB_AUTO_RX] = auto_r;
          abort_ev              = 1'b1;
        end else if (tick && (ta_cnt_r + 6'h01) == turnaround_r) begin
          if (LINE_BUSY_I) begin
            cause_set[CB_SW_BUSY]   = ~auto_r;
            cause_set[CB_AUTO_BUSY] = auto_r;
            abort_ev                = 1'b1;
          end else begin
            state_nxt = ST_PRE;
          end
        end
      end
      ST_PRE: begin
        if (bit_end && (pre_cnt_r + 7'h01) == preamble_r) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (have_byte_r && bit_end && bit_idx_r == 3'd7 && last_r) begin
          state_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        if (RX_HRST_I ||
            (RX_MSG_I && !RX_GOODCRC_I && !RX_PING_I)) begin
          cause_set[CB_PROTO_ERR] = 1'b1;
          abort_ev                = 1'b1;
        end else if ((RX_MSG_I && RX_GOODCRC_I) || ACK_TIMEOUT_I) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // software abort outranks the per-state outcome
    if (abort_wr && state_r != ST_IDLE) begin
      cause_set[CB_SW_ABORT] = ~auto_r;
      abort_ev               = 1'b1;
    end
    if (abort_ev) begin
      state_nxt = ST_IDLE;
    end
  end

  // locked while nonzero; a set meeting the final clear is lost
  always_comb begin
    cause_clr = 8'h00;
    if (wr_commit && idx == IDX_ABORTCAUSE) begin
      cause_clr = PWDATA_I[7:0] & CAUSE_MASK;
    end
    cause_nxt = cause_r & ~cause_clr;
    if (cause_r == 8'h00) begin
      cause_nxt = cause_set & CAUSE_MASK;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      state_r <= ST_IDLE;
      auto_r  <= 1'b0;
      cause_r <= CAUSE_RST;
    end else begin
      state_r <= state_nxt;
      auto_r  <= auto_nxt;
      cause_r <= cause_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit serialiser: preamble then bytes lsb first
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I || state_r != ST_PRE) begin
      pre_cnt_r <= 7'h00;
    end else if (bit_end) begin
      pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end

  // an empty buffer mid-frame holds the line until a byte arrives
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I || (state_r != ST_DATA && !pop)) begin
      have_byte_r <= 1'b0;
      bit_idx_r   <= 3'd0;
      shift_r     <= 8'h00;
      last_r      <= 1'b0;
    end else if (pop) begin
      have_byte_r <= 1'b1;
      bit_idx_r   <= 3'd0;
      shift_r     <= fifo_mem[rd_ptr_r].data;
      last_r      <= fifo_mem[rd_ptr_r].last;
    end else if (have_byte_r && bit_end) begin
      bit_idx_r <= bit_idx_r + 3'd1;
      if (bit_idx_r == 3'd7) begin
        have_byte_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      tx_bit_r     <= 1'b0;
      tx_active_r  <= 1'b0;
      tx_aborted_r <= 1'b0;
    end else begin
      if (state_r == ST_PRE) begin
        tx_bit_r <= pre_cnt_r[0];
      end else if (state_r == ST_DATA && have_byte_r) begin
        tx_bit_r <= shift_r[bit_idx_r];
      end else begin
        tx_bit_r <= 1'b0;
      end
      tx_active_r  <= (state_r == ST_PRE) || (state_r == ST_DATA);
      tx_aborted_r <= abort_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign PRDATA_O     = prdata_r;
  assign PREADY_O     = pready_r;
  assign PSLVERR_O    = pslverr_r;
  assign S_READY_O    = s_ready_r;
  assign TX_BIT_O     = tx_bit_r;
  assign TX_ACTIVE_O  = tx_active_r;
  assign TX_ABORTED_O = tx_aborted_r;

endmodule : pdt_tx_timing

// >>> pdt_tx_timing_props.sv
// Purpose: port-level assertions for pdt_tx_timing
// Assumes: bound to the top module, one clock domain
// Notes:   bit phase counter assumes no stall between bytes
`timescale 1ns/1ps
module pdt_tx_timing_props
  import pdt_pkg::*;
(
  input wire logic              CLOCK_I,
  input wire logic              RESETN_I,
  input wire logic              PSEL_I,
  input wire logic              PENABLE_I,
  input wire logic              PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0]       PWDATA_I,
  input wire logic [31:0]       PRDATA_O,
  input wire logic              PREADY_O,
  input wire logic              LINE_BUSY_I,
  input wire logic              TX_BIT_O,
  input wire logic              TX_ACTIVE_O,
  input wire logic              TX_ABORTED_O
);
  logic       wr_ok;
  logic       en_r;
  logic [7:0] bp_r;
  logic [7:0] ph_r;

  assign wr_ok = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  // shadow of the bit period and enable, taken from committed writes
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      bp_r <= BITPERIOD_RST;
      en_r <= 1'b0;
    end else if (wr_ok && PADDR_I[15:2] == IDX_BITPERIOD) begin
      bp_r <= PWDATA_I[7:0];
    end else if (wr_ok && PADDR_I[15:2] == IDX_CONTROL) begin
      en_r <= PWDATA_I[CTL_ENABLE];
    end
  end

  // position inside the current bit, zero on the first cycle of a bit
  always_ff @(posedge CLOCK_I) begin
    if (!TX_ACTIVE_O || ph_r == bp_r) begin
      ph_r <= 8'h00;
    end else begin
      ph_r <= ph_r + 8'h01;
    end
  end

  chk_ready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O
    |=> PREADY_O) else $error("pready not one cycle after access");
  chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("pready longer than one cycle");
  chk_pre_rsvd: assert property (
    PREADY_O && !PWRITE_I && PADDR_I[15:2] == IDX_PREAMBLE
    |-> PRDATA_O[31:7] == 25'h0) else $error("preamble upper bits set");
  chk_abort_pulse: assert property (
    TX_ABORTED_O |=> !TX_ABORTED_O) else $error("abort pulse too long");
  chk_idle_low: assert property (!TX_ACTIVE_O |-> !TX_BIT_O)
    else $error("line high while idle");
  chk_pre_first: assert property ($rose(TX_ACTIVE_O) |-> !TX_BIT_O)
    else $error("preamble starts with one");
  chk_bit_edge: assert property (
    TX_ACTIVE_O && $past(TX_ACTIVE_O) && $changed(TX_BIT_O) |-> ph_r == 8'h00)
    else $error("line bit changed inside a bit period");
  chk_go_off: assert property (wr_ok && PADDR_I[15:2] == IDX_CONTROL &&
    PWDATA_I[CTL_GO] && !PWDATA_I[CTL_ENABLE] && !en_r
    |-> ##[1:2] TX_ABORTED_O) else $error("go while disabled not aborted");
  chk_busy_start: assert property (
    $rose(TX_ACTIVE_O) |-> !$past(LINE_BUSY_I, 2))
    else $error("frame started on a busy line");
endmodule : pdt_tx_timing_props

// >>> pdt_far_port.sv
// Purpose: far power delivery port answering each transmitted frame
// Assumes: bench picks the reply mode before a frame ends
// Notes:   never raises ack timeout; reply comes 10 cycles after a frame
`timescale 1ns/1ps
module pdt_far_port (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       active_i,
  input  wire logic       busy_i,
  input  wire logic       rx_go_i,
  input  wire logic [1:0] mode_i,
  output logic            line_busy_o,
  output logic            rx_start_o,
  output logic            rx_hrst_o,
  output logic            rx_msg_o,
  output logic            rx_goodcrc_o,
  output logic            rx_ping_o,
  output logic            ack_to_o
);
  logic       act_q;
  logic [3:0] cnt_r;
  logic       ok;

  // mode 0 goodcrc, 1 other message, 2 hard reset, 3 ping then goodcrc
  assign ok = mode_i == 2'd0 || mode_i == 2'd3;

  always_ff @(posedge clk_i) begin
    act_q        <= active_i;
    line_busy_o  <= busy_i;
    rx_start_o   <= rx_go_i || cnt_r == 4'd3;
    rx_hrst_o    <= cnt_r == 4'd1 && mode_i == 2'd2;
    rx_msg_o     <= (cnt_r == 4'd1 && mode_i != 2'd2) ||
                    (cnt_r == 4'd5 && mode_i == 2'd3);
    rx_goodcrc_o <= cnt_r == 4'd1 && ok;
    rx_ping_o    <= cnt_r == 4'd5 && mode_i == 2'd3;
    ack_to_o     <= 1'b0;
    if (!rst_n_i) begin
      cnt_r <= 4'd0;
    end else if (act_q && !active_i) begin
      cnt_r <= 4'd9;
    end else if (cnt_r != 4'd0) begin
      cnt_r <= cnt_r - 4'd1;
    end
  end
endmodule : pdt_far_port

// >>> pdt_tx_timing_test.sv
// Purpose: self-checking bench for pdt_tx_timing
// Assumes: far port model replies after each frame
// Notes:   expected reads and line bits queue up; monitors pop them
`timescale 1ns/1ps
module pdt_tx_timing_test
  import pdt_pkg::*;
;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, sval = 0;
  logic        retry = 0, busy = 0, rx_go = 0;
  logic [1:0]  mode = 0;
  logic [15:0] padr = 0;
  logic [31:0] pwd = 0, prd;
  logic        prdy, perr, srdy, lbusy, rxs, rxh, rxm, rxg, rxp, ackto;
  logic        tbit, tact, tab;
  pdt_word_t   sw = '0;
  logic [32:0] rd_q[$];
  logic        bit_q[$];
  int          fail_count = 0, check_count = 0, seed = 83, npre, bp;
  // {auto, event, expected cause}; events: busy rx abort good other hrst ping
  localparam logic [11:0] CASES [9] = '{12'h004, 12'h140, 12'h810, 12'h920,
    12'h202, 12'h300, 12'h480, 12'h580, 12'h600};

  always #2.5 clk = ~clk;

  pdt_tx_timing uut (.CLOCK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .S_WORD_I(sw),
    .S_VALID_I(sval), .S_READY_O(srdy), .RETRY_REQ_I(retry),
    .LINE_BUSY_I(lbusy), .RX_START_I(rxs), .RX_HRST_I(rxh),
    .RX_MSG_I(rxm), .RX_GOODCRC_I(rxg), .RX_PING_I(rxp),
    .ACK_TIMEOUT_I(ackto), .TX_BIT_O(tbit), .TX_ACTIVE_O(tact),
    .TX_ABORTED_O(tab));
  pdt_far_port far (.clk_i(clk), .rst_n_i(rst_n), .active_i(tact),
    .busy_i(busy), .rx_go_i(rx_go), .mode_i(mode), .line_busy_o(lbusy),
    .rx_start_o(rxs), .rx_hrst_o(rxh), .rx_msg_o(rxm),
    .rx_goodcrc_o(rxg), .rx_ping_o(rxp), .ack_to_o(ackto));

  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR prdata exp %h got %h", e, g);
    end
  endtask : cmp_rd

  task automatic cmp_bit(input logic e);
    check_count++;
    if (tbit !== e) begin
      fail_count++;
      $display("ERROR tx_bit exp %b got %b", e, tbit);
    end
  endtask : cmp_bit

  task automatic xfer(input logic w, input logic [13:0] i,
                      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr  <= w;
    padr <= {i, 2'b00};
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(negedge clk); while (prdy !== 1'b1 && ++n < 50);
    @(posedge clk);
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
    if (n == 50) begin
      fail_count++;
      give_verdict();
    end
  endtask : xfer

  task automatic rd(input logic [13:0] i, input logic [32:0] e);
    rd_q.push_back(e);
    xfer(1'b0, i, 32'h0);
  endtask : rd

  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    xfer(1'b1, i, d);
  endtask : wr

  task automatic send(input logic [7:0] b, input logic l);
    int n;
    n = 0;
    sw   <= '{data: b, last: l};
    sval <= 1'b1;
    do @(negedge clk); while (srdy !== 1'b1 && ++n < 3000);
    @(posedge clk);
    sval <= 1'b0;
    @(posedge clk);
    if (n == 3000) begin
      fail_count++;
      give_verdict();
    end
  endtask : send

  task automatic wait_done();
    int n;
    n = 0;
    do @(negedge clk);
    while (tab !== 1'b1 && !(rxm === 1'b1 && rxg === 1'b1) && ++n < 3000);
    repeat (4) @(posedge clk);
    if (n == 3000) begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_done

  //////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (psel && pen && !pwr && prdy === 1'b1 && rd_q.size() > 0) begin
      cmp_rd(rd_q.pop_front(), {perr, prd});
    end
  end

  // sample each expected bit in the middle of its period
  initial forever begin
    @(negedge clk);
    if (tact === 1'b1 && bit_q.size() > 0) begin
      repeat (bp / 2) @(negedge clk);
      while (bit_q.size() > 0) begin
        cmp_bit(bit_q.pop_front());
        repeat (bp + 1) @(negedge clk);
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    logic [11:0] c;
    logic [23:0] d;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(IDX_PREAMBLE, 33'h40);
    rd(IDX_BITPERIOD, 33'h0);
    rd(IDX_TURNAROUND, 33'h15);
    rd(IDX_ABORTCAUSE, 33'h0);
    rd(14'h1a05, 33'h1_0000_0000);
    wr(IDX_PREAMBLE, 32'hff);
    rd(IDX_PREAMBLE, 33'h7f);
    wr(IDX_TURNAROUND, 32'hff);
    rd(IDX_TURNAROUND, 33'h3f);
    npre = 2 * (2 + ($random(seed) & 7));
    bp = 2 + ($random(seed) & 3);
    wr(IDX_PREAMBLE, 32'(npre));
    wr(IDX_BITPERIOD, 32'(bp));
    rd(IDX_BITPERIOD, 33'(bp));
    wr(IDX_TURNAROUND, 32'h2);
    wr(IDX_CONTROL, 32'h1);
    wr(IDX_CONTROL, 32'h4);
    busy <= 1'b1;
    wr(IDX_CONTROL, 32'h5);
    wait_done();
    busy <= 1'b0;
    rd(IDX_ABORTCAUSE, 33'h1);
    wr(IDX_ABORTCAUSE, 32'hff);
    rd(IDX_ABORTCAUSE, 33'h0);
    for (int k = 0; k < 9; k++) begin
      c = CASES[k];
      d = 24'($random(seed));
      mode <= c[9:8] + 2'd1;
      busy <= (c[10:8] == 3'd0);
      if (c[10:8] > 3'd2) begin
        for (int i = 0; i < npre; i++) bit_q.push_back(i[0]);
        for (int i = 0; i < 24; i++) bit_q.push_back(d[i]);
        send(d[7:0], 1'b0);
        send(d[15:8], 1'b0);
      end else begin
        send(d[7:0], 1'b1);
      end
      if (c[11]) begin
        retry <= 1'b1;
        @(posedge clk);
        retry <= 1'b0;
      end else begin
        wr(IDX_CONTROL, 32'h5);
      end
      // buffer is full here, so this waits for the first byte to drain
      if (c[10:8] > 3'd2) send(d[23:16], 1'b1);
      if (c[10:8] == 3'd1) begin
        rx_go <= 1'b1;
        @(posedge clk);
        rx_go <= 1'b0;
      end
      if (c[10:8] == 3'd2) begin
        for (int n = 0; n < 999 && tact !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        wr(IDX_CONTROL, 32'h6);
      end
      wait_done();
      busy <= 1'b0;
      rd(IDX_ABORTCAUSE, {25'h0, c[7:0]});
      wr(IDX_ABORTCAUSE, 32'hff);
    end
    if (rd_q.size() + bit_q.size() > 0) fail_count++;
    give_verdict();
  end
endmodule : pdt_tx_timing_test

bind pdt_tx_timing pdt_tx_timing_props chk (.*);
